/* File: bd_engine_pkg.sv */
// shared constants for the buffer descriptor engine
package bd_engine_pkg;
  // descriptor status byte layout
  localparam int OWNER_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TGLCHK_BIT = 3;
  localparam int BUFFER_STALL_ENABLE_BIT = 2;
  localparam int PID_LSB = 2;
  // byte offsets inside one descriptor
  localparam logic [1:0] OFS_STATUS = 2'h0;
  localparam logic [1:0] OFS_COUNT = 2'h1;
  localparam logic [1:0] OFS_ADDR_LO = 2'h2;
  localparam logic [1:0] OFS_ADDR_HI = 2'h3;
  // buffering modes
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_EP0_OUT = 2'h1;
  localparam logic [1:0] MODE_ALL = 2'h2;
  // token pids
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_SETUP = 4'hd;
  // handshakes reported to the serial engine
  localparam logic [1:0] HS_ACK = 2'h0;
  localparam logic [1:0] HS_NAK = 2'h1;
  localparam logic [1:0] HS_STALL = 2'h2;
  // register byte addresses on the avalon slave
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_STALL = 4'h8;
  localparam logic [3:0] REG_POINTER = 4'hc;
  // reset values
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [15:0] STALL_RESET = 16'h0000;
endpackage

/* File: bd_slot_map.sv */
// descriptor slot lookup from endpoint, direction, mode and pointer
`timescale 1ns/1ps
module bd_slot_map (
  input wire logic [3:0] ep_in, // endpoint number
  input wire logic dir_in_in, // 1 for IN, 0 for OUT/SETUP
  input wire logic [1:0] mode_in, // buffering mode
  input wire logic odd_in, // ping-pong pointer
  output logic [5:0] slot_out, // descriptor index
  output logic pingpong_out // endpoint uses two sets
);
  // fixed slots, disabled endpoints simply leave holes
  always_comb begin
    slot_out = {1'b0, ep_in, dir_in_in};
    pingpong_out = 1'b0;
    unique case (mode_in)
      bd_engine_pkg::MODE_EP0_OUT: begin
        if (ep_in == 4'h0 && !dir_in_in) begin
          slot_out = {5'h00, odd_in};
          pingpong_out = 1'b1;
        end else begin
          slot_out = 6'({1'b0, ep_in, dir_in_in} + 6'h01);
        end
      end
      bd_engine_pkg::MODE_ALL: begin
        slot_out = {ep_in, dir_in_in, odd_in};
        pingpong_out = 1'b1;
      end
      default: begin
        // mode 0 and reserved code 3 use plain layout
        slot_out = {1'b0, ep_in, dir_in_in};
        pingpong_out = 1'b0;
      end
    endcase
  end
endmodule

/* File: bd_engine.sv */
// buffer descriptor engine of the usb device serial engine
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module bd_engine #(
  parameter int RAM_AW = 10 // usb ram byte address width
) (
  input wire logic sys_clk_in, // 250 MHz clock
  input wire logic srst_in, // sync reset, module enable low
  // avalon-mm slave
  input wire logic [3:0] avs_address_in, // byte address
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic [31:0] avs_writedata_in, // write data
  input wire logic [3:0] avs_byteenable_in, // byte lanes
  output logic [31:0] avs_readdata_out, // read data
  output logic avs_waitrequest_out, // stall the master
  // token from the serial engine
  input wire logic tok_valid_in, // one-cycle token strobe
  input wire logic [3:0] tok_pid_in, // token pid
  input wire logic [3:0] tok_ep_in, // endpoint
  input wire logic tok_data1_in, // out packet was data1
  input wire logic [9:0] tok_len_in, // bytes received or sent
  input wire logic tok_err_in, // packet error
  output logic tok_done_out, // one-cycle answer strobe
  output logic [1:0] tok_hs_out, // handshake to send
  output logic [15:0] buf_addr_out, // buffer start used
  output logic [9:0] buf_limit_out, // bytes allowed
  output logic tok_store_out, // data may be kept
  output logic transfer_done_flag_out, // completion pulse
  output logic stall_event_out, // stall issued pulse
  // usb ram port, one byte per cycle
  output logic [RAM_AW-1:0] ram_addr_out, // byte address
  output logic ram_we_out, // write strobe
  output logic [7:0] ram_wdata_out, // write byte
  input wire logic [7:0] ram_rdata_in // read byte, 1 cycle
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RD_STAT = 6'b000010,
    ST_RD_CNT = 6'b000100,
    ST_RD_ALO = 6'b001000,
    ST_RD_AHI = 6'b010000,
    ST_WRITE = 6'b100000
  } state_type;

  typedef struct packed {
    state_type st;
    logic [1:0] mode;
    logic [15:0] ep_stall;
    logic [15:0] pointer;
    logic last_odd;
    logic [3:0] pid;
    logic [3:0] ep;
    logic data1;
    logic [9:0] len;
    logic err;
    logic odd;
    logic [5:0] slot;
    logic [7:0] stat;
    logic [7:0] cnt;
    logic [7:0] alo;
    logic [1:0] wr_idx;
    logic [7:0] wr_stat;
    logic [7:0] wr_cnt;
    logic done;
    logic [1:0] hs;
    logic store;
    logic trn;
    logic stall_ev;
    logic [15:0] addr;
    logic [9:0] limit;
    logic [31:0] rdata;
    logic ack;
  } state_all_type;

  state_all_type cur_ff;
  state_all_type nxt_ff;
  logic [5:0] slot_w;
  logic pp_w;
  logic [3:0] wbase;

  bd_slot_map u_map (
    .ep_in(cur_ff.ep),
    .dir_in_in(cur_ff.pid == bd_engine_pkg::PID_IN),
    .mode_in(cur_ff.mode),
    .odd_in(cur_ff.odd),
    .slot_out(slot_w),
    .pingpong_out(pp_w)
  );

  // byte address of one descriptor field
  function automatic logic [RAM_AW-1:0] bd_addr(input logic [5:0] s,
      input logic [1:0] o);
    bd_addr = RAM_AW'({s, o});
  endfunction

  assign wbase = 4'(cur_ff.ep);

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.done = 1'b0;
    nxt_ff.trn = 1'b0;
    nxt_ff.stall_ev = 1'b0;
    nxt_ff.ack = 1'b0;
    ram_we_out = 1'b0;
    ram_wdata_out = 8'h00;
    ram_addr_out = bd_addr(cur_ff.slot, bd_engine_pkg::OFS_STATUS);
    // write lands only at the edge where waitrequest is sampled low
    if (avs_write_in && cur_ff.ack) begin
        unique case (avs_address_in)
          bd_engine_pkg::REG_CONFIG: begin
            if (avs_byteenable_in[0]) begin
              nxt_ff.mode = avs_writedata_in[1:0];
              if (avs_writedata_in[4])
                nxt_ff.pointer = 16'h0000;
            end
          end
          bd_engine_pkg::REG_STALL: begin
            // write one to clear endpoint stall flags
            if (avs_byteenable_in[0])
              nxt_ff.ep_stall[7:0] = cur_ff.ep_stall[7:0]
                  & ~avs_writedata_in[7:0];
            if (avs_byteenable_in[1])
              nxt_ff.ep_stall[15:8] = cur_ff.ep_stall[15:8]
                  & ~avs_writedata_in[15:8];
          end
          default: ;
        endcase
    end
    // register slave, one wait cycle via ack
    if ((avs_read_in || avs_write_in) && !cur_ff.ack) begin
      nxt_ff.ack = 1'b1;
      nxt_ff.rdata = 32'h0000_0000;
      if (avs_read_in) begin
        unique case (avs_address_in)
          bd_engine_pkg::REG_CONFIG: nxt_ff.rdata = {30'h0, cur_ff.mode};
          bd_engine_pkg::REG_STATUS:
            nxt_ff.rdata = {27'h0, cur_ff.last_odd, cur_ff.ep};
          bd_engine_pkg::REG_STALL: nxt_ff.rdata = {16'h0, cur_ff.ep_stall};
          bd_engine_pkg::REG_POINTER: nxt_ff.rdata = {16'h0, cur_ff.pointer};
          default: nxt_ff.rdata = 32'h0000_0000;
        endcase
      end
    end
    unique case (cur_ff.st)
      ST_IDLE: begin
        if (tok_valid_in) begin
          nxt_ff.pid = tok_pid_in;
          nxt_ff.ep = tok_ep_in;
          nxt_ff.data1 = tok_data1_in;
          nxt_ff.len = tok_len_in;
          nxt_ff.err = tok_err_in;
          nxt_ff.odd = 1'b0;
          nxt_ff.st = ST_RD_STAT;
        end
      end
      ST_RD_STAT: begin
        // pointer applies only where the endpoint ping-pongs
        nxt_ff.odd = cur_ff.pointer[wbase];
        nxt_ff.slot = slot_w;
        ram_addr_out = bd_addr(cur_ff.slot, bd_engine_pkg::OFS_STATUS);
        nxt_ff.st = ST_RD_CNT;
      end
      ST_RD_CNT: begin
        // odd resolved now; slot valid from here on
        nxt_ff.slot = slot_w;
        if (!pp_w)
          nxt_ff.slot = slot_w;
        ram_addr_out = bd_addr(slot_w, bd_engine_pkg::OFS_STATUS);
        nxt_ff.st = ST_RD_ALO;
      end
      ST_RD_ALO: begin
        nxt_ff.stat = ram_rdata_in;
        ram_addr_out = bd_addr(cur_ff.slot, bd_engine_pkg::OFS_COUNT);
        nxt_ff.st = ST_RD_AHI;
      end
      ST_RD_AHI: begin
        nxt_ff.cnt = ram_rdata_in;
        ram_addr_out = bd_addr(cur_ff.slot, bd_engine_pkg::OFS_ADDR_LO);
        nxt_ff.wr_idx = 2'h0;
        nxt_ff.st = ST_WRITE;
      end
      ST_WRITE: begin
        // address low byte arrived; high byte read in parallel
        ram_addr_out = bd_addr(cur_ff.slot, bd_engine_pkg::OFS_ADDR_HI);
        if (cur_ff.wr_idx == 2'h0) begin
          nxt_ff.alo = ram_rdata_in;
          nxt_ff.wr_idx = 2'h1;
        end else if (cur_ff.wr_idx == 2'h1) begin
          // decide the answer for this token
          nxt_ff.addr = {ram_rdata_in, cur_ff.alo};
          nxt_ff.limit = {cur_ff.stat[1:0], cur_ff.cnt};
          nxt_ff.done = 1'b1;
          nxt_ff.hs = bd_engine_pkg::HS_NAK;
          nxt_ff.store = 1'b0;
          nxt_ff.wr_stat = cur_ff.stat;
          nxt_ff.wr_cnt = cur_ff.cnt;
          nxt_ff.wr_idx = 2'h3;
          nxt_ff.st = ST_IDLE;
          if (!cur_ff.stat[bd_engine_pkg::OWNER_BIT]) begin
            nxt_ff.hs = bd_engine_pkg::HS_NAK;
          end else if (cur_ff.stat[bd_engine_pkg::BUFFER_STALL_ENABLE_BIT]
              && cur_ff.pid != bd_engine_pkg::PID_SETUP) begin
            nxt_ff.hs = bd_engine_pkg::HS_STALL;
            nxt_ff.stall_ev = 1'b1;
            nxt_ff.ep_stall[wbase] = 1'b1;
          end else if (cur_ff.err) begin
            nxt_ff.hs = bd_engine_pkg::HS_NAK;
          end else if (cur_ff.pid != bd_engine_pkg::PID_IN
              && cur_ff.len > {cur_ff.stat[1:0], cur_ff.cnt}) begin
            nxt_ff.hs = bd_engine_pkg::HS_NAK;
          end else if (cur_ff.pid == bd_engine_pkg::PID_OUT
              && cur_ff.stat[bd_engine_pkg::TGLCHK_BIT]
              && cur_ff.data1 != cur_ff.stat[bd_engine_pkg::TOGGLE_BIT]) begin
            nxt_ff.hs = bd_engine_pkg::HS_ACK;
          end else begin
            // completion: write back pid and count, release
            nxt_ff.hs = bd_engine_pkg::HS_ACK;
            nxt_ff.store = 1'b1;
            nxt_ff.trn = 1'b1;
            nxt_ff.wr_cnt = cur_ff.len[7:0];
            nxt_ff.wr_stat = {1'b0, cur_ff.stat[bd_engine_pkg::TOGGLE_BIT],
                cur_ff.pid, cur_ff.len[9:8]};
            nxt_ff.wr_idx = 2'h2;
            nxt_ff.st = ST_WRITE;
            nxt_ff.last_odd = cur_ff.odd;
            if (pp_w)
              nxt_ff.pointer[wbase] = ~cur_ff.pointer[wbase];
            if (cur_ff.pid == bd_engine_pkg::PID_SETUP)
              nxt_ff.ep_stall[wbase] = 1'b0;
          end
        end else begin
          // two write cycles: count then status (status last)
          ram_we_out = 1'b1;
          if (cur_ff.wr_idx == 2'h2) begin
            ram_addr_out = bd_addr(cur_ff.slot, bd_engine_pkg::OFS_COUNT);
            ram_wdata_out = cur_ff.wr_cnt;
            nxt_ff.wr_idx = 2'h3;
          end else begin
            ram_addr_out = bd_addr(cur_ff.slot, bd_engine_pkg::OFS_STATUS);
            ram_wdata_out = cur_ff.wr_stat;
            nxt_ff.st = ST_IDLE;
          end
        end
      end
      default: nxt_ff.st = ST_IDLE;
    endcase
  end

  // one register for all state; reset is module enable low
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      cur_ff <= '0;
      cur_ff.st <= ST_IDLE;
      cur_ff.mode <= bd_engine_pkg::MODE_RESET;
      cur_ff.ep_stall <= bd_engine_pkg::STALL_RESET;
      cur_ff.pointer <= 16'h0000;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !cur_ff.ack;
  assign avs_readdata_out = cur_ff.rdata;
  assign tok_done_out = cur_ff.done;
  assign tok_hs_out = cur_ff.hs;
  assign buf_addr_out = cur_ff.addr;
  assign buf_limit_out = cur_ff.limit;
  assign tok_store_out = cur_ff.store;
  assign transfer_done_flag_out = cur_ff.trn;
  assign stall_event_out = cur_ff.stall_ev;

  // stall answer comes with a stall event pulse
  property p_stall_pulse;
    @(posedge sys_clk_in) disable iff (srst_in)
      (tok_done_out && tok_hs_out == bd_engine_pkg::HS_STALL)
      |-> stall_event_out;
  endproperty
  a_stall_pulse: assert property (p_stall_pulse)
    else $error("stall without event");

  // completion pulse comes in the same cycle as the first of two back-to-back ram writes
  sequence s_wb;
    ram_we_out ##1 ram_we_out;
  endsequence
  property p_writeback;
    @(posedge sys_clk_in) disable iff (srst_in)
      transfer_done_flag_out |-> s_wb;
  endproperty
  a_writeback: assert property (p_writeback)
    else $error("missing write back");

  // nak never carries a completion
  property p_nak_quiet;
    @(posedge sys_clk_in) disable iff (srst_in)
      (tok_done_out && tok_hs_out == bd_engine_pkg::HS_NAK)
      |-> !transfer_done_flag_out && !tok_store_out;
  endproperty
  a_nak_quiet: assert property (p_nak_quiet)
    else $error("nak with completion");

  // the status write releases ownership
  property p_release;
    @(posedge sys_clk_in) disable iff (srst_in)
      transfer_done_flag_out |-> ##1 (ram_we_out && !ram_wdata_out[7]);
  endproperty
  a_release: assert property (p_release)
    else $error("owner not cleared");

  // token answered seven cycles after it is taken
  property p_answer;
    @(posedge sys_clk_in) disable iff (srst_in)
      (tok_valid_in && cur_ff.st == ST_IDLE) |-> ##7 tok_done_out;
  endproperty
  a_answer: assert property (p_answer)
    else $error("token not answered");

  // bus answer after exactly one wait cycle
  property p_bus;
    @(posedge sys_clk_in) disable iff (srst_in)
      ($rose(avs_read_in) || $rose(avs_write_in))
      |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus answer late");

  // completion toggles the pointer in all-ping-pong mode
  property p_toggle;
    @(posedge sys_clk_in) disable iff (srst_in)
      (transfer_done_flag_out && cur_ff.mode == bd_engine_pkg::MODE_ALL)
      |-> cur_ff.pointer[cur_ff.ep] != $past(cur_ff.pointer[cur_ff.ep]);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("pointer not toggled");

  // written count equals the packet length
  property p_count;
    @(posedge sys_clk_in) disable iff (srst_in)
      transfer_done_flag_out |-> (ram_wdata_out == cur_ff.len[7:0]);
  endproperty
  a_count: assert property (p_count)
    else $error("count written wrong");
endmodule

/* File: usb_host_model.sv */
// token source standing in for the usb host side of the engine
`timescale 1ns/1ps
module usb_host_model (
  input wire logic sys_clk_in, // module clock
  output logic tok_valid_out, // token strobe
  output logic [3:0] tok_pid_out, // token pid
  output logic [3:0] tok_ep_out, // endpoint
  output logic tok_data1_out, // packet was data1
  output logic [9:0] tok_len_out, // bytes moved
  output logic tok_err_out // packet error
);
  initial begin
    tok_valid_out = 1'b0;
    tok_pid_out = 4'h0;
    tok_ep_out = 4'h0;
    tok_data1_out = 1'b0;
    tok_len_out = 10'h000;
    tok_err_out = 1'b0;
  end

  // one-cycle token; qualifiers inverted after so stale values never match
  task automatic send(input logic [3:0] p, e, input logic d1,
                      input logic [9:0] l, input logic er);
    @(posedge sys_clk_in);
    tok_valid_out <= 1'b1;
    tok_pid_out <= p;
    tok_ep_out <= e;
    tok_data1_out <= d1;
    tok_len_out <= l;
    tok_err_out <= er;
    @(posedge sys_clk_in);
    tok_valid_out <= 1'b0;
    tok_pid_out <= ~p;
    tok_ep_out <= ~e;
    tok_data1_out <= ~d1;
    tok_len_out <= ~l;
    tok_err_out <= ~er;
  endtask
endmodule

/* File: tb.sv */
// self-checking bench for the buffer descriptor engine
`timescale 1ns/1ps
module tb;
  logic sys_clk_in, srst_in, rd, wr, wreq, wt;
  logic [3:0] adr;
  logic [31:0] wd, rdo, rdat;
  logic tv, td1, terr, done, st, xf, se, rwe, tst;
  logic [3:0] tp, te;
  logic [9:0] tl, bl, ra, tbl;
  logic [1:0] hs, ths;
  logic [15:0] ba, tba;
  logic [7:0] rwd, rrd;
  logic [7:0] ram [0:1023];
  int error_cnt, tests_run, cyc, xfer_cnt, stall_cnt, xd, sd;

  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  usb_host_model host_u (.sys_clk_in(sys_clk_in), .tok_valid_out(tv),
    .tok_pid_out(tp), .tok_ep_out(te), .tok_data1_out(td1),
    .tok_len_out(tl), .tok_err_out(terr));

  bd_engine dut_u (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdo), .avs_waitrequest_out(wreq),
    .tok_valid_in(tv), .tok_pid_in(tp), .tok_ep_in(te),
    .tok_data1_in(td1), .tok_len_in(tl), .tok_err_in(terr),
    .tok_done_out(done), .tok_hs_out(hs), .buf_addr_out(ba),
    .buf_limit_out(bl), .tok_store_out(st),
    .transfer_done_flag_out(xf), .stall_event_out(se),
    .ram_addr_out(ra), .ram_we_out(rwe), .ram_wdata_out(rwd),
    .ram_rdata_in(rrd));

  // usb ram, data one cycle after address
  always @(posedge sys_clk_in) begin
    if (rwe === 1'b1) ram[ra] <= rwd;
    rrd <= ram[ra];
  end

  // pulse counters and hang guard; whole run is well under 6000 cycles
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (xf === 1'b1) xfer_cnt <= xfer_cnt + 1;
    if (se === 1'b1) stall_cnt <= stall_cnt + 1;
    if (cyc == 6000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // avalon cycle: request held until waitrequest seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_in);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge sys_clk_in);
      wt = wreq;
      rdat = rdo;
    end while (wt !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rr(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask

  // firmware side: fills one descriptor while the engine is idle
  task automatic bd(input logic [5:0] s, input logic [7:0] f, c, lo, hi);
    ram[{2'b00, s, bd_engine_pkg::OFS_STATUS}] = f;
    ram[{2'b00, s, bd_engine_pkg::OFS_COUNT}] = c;
    ram[{2'b00, s, bd_engine_pkg::OFS_ADDR_LO}] = lo;
    ram[{2'b00, s, bd_engine_pkg::OFS_ADDR_HI}] = hi;
  endtask

  function automatic logic [7:0] rb(input logic [5:0] s,
                                    input logic [1:0] o);
    return ram[{2'b00, s, o}];
  endfunction

  // one token; the spacing afterwards covers the write back
  task automatic tk(input logic [3:0] p, e, input logic d1,
                    input logic [9:0] l, input logic er);
    int n;
    int x0;
    int s0;
    x0 = xfer_cnt;
    s0 = stall_cnt;
    host_u.send(p, e, d1, l, er);
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (done !== 1'b1 && n < 20);
    chk(n, 7);
    ths = hs;
    tst = st;
    tba = ba;
    tbl = bl;
    repeat (4) @(posedge sys_clk_in);
    xd = xfer_cnt - x0;
    sd = stall_cnt - s0;
  endtask

  task automatic t_regs();
    rr(bd_engine_pkg::REG_CONFIG, 0);
    rr(bd_engine_pkg::REG_STALL, 0);
    rr(bd_engine_pkg::REG_POINTER, 0);
    bus(1'b1, 4'h2, 32'hffff_ffff);
    rr(4'h2, 0);
    rr(bd_engine_pkg::REG_CONFIG, 0);
    $display("registers done");
  endtask

  task automatic t_out();
    bd(6'd2, 8'hc1, 8'h20, 8'h80, 8'h04);
    tk(bd_engine_pkg::PID_OUT, 4'h1, 1'b0, 10'h105, 1'b0);
    chk(ths, bd_engine_pkg::HS_ACK);
    chk({tst, tba, tbl}, {1'b1, 16'h0480, 10'h120});
    chk(xd, 1);
    chk(rb(6'd2, bd_engine_pkg::OFS_COUNT), 8'h05);
    chk(rb(6'd2, bd_engine_pkg::OFS_STATUS), 8'h45);
    rr(bd_engine_pkg::REG_STATUS, 32'h01);
    tk(bd_engine_pkg::PID_OUT, 4'h1, 1'b0, 10'h005, 1'b0);
    chk({ths, xd[1:0]}, {bd_engine_pkg::HS_NAK, 2'b00});
    bd(6'd2, 8'h80, 8'h10, 8'h80, 8'h04);
    tk(bd_engine_pkg::PID_OUT, 4'h1, 1'b0, 10'h011, 1'b0);
    chk(ths, bd_engine_pkg::HS_NAK);
    chk(rb(6'd2, bd_engine_pkg::OFS_COUNT), 8'h10);
    chk(rb(6'd2, bd_engine_pkg::OFS_STATUS), 8'h80);
    tk(bd_engine_pkg::PID_OUT, 4'h1, 1'b0, 10'h010, 1'b1);
    chk({ths, xd[1:0]}, {bd_engine_pkg::HS_NAK, 2'b00});
    tk(bd_engine_pkg::PID_OUT, 4'h1, 1'b0, 10'h010, 1'b0);
    chk(ths, bd_engine_pkg::HS_ACK);
    chk(rb(6'd2, bd_engine_pkg::OFS_STATUS), 8'h04);
    $display("out done");
  endtask

  task automatic t_in();
    // buffer running past the end of the usb ram window: the engine must not object
    bd(6'd3, 8'h83, 8'hff, 8'h23, 8'h01);
    tk(bd_engine_pkg::PID_IN, 4'h1, 1'b0, 10'h2a5, 1'b0);
    chk(ths, bd_engine_pkg::HS_ACK);
    chk({tba, tbl}, {16'h0123, 10'h3ff});
    chk(rb(6'd3, bd_engine_pkg::OFS_COUNT), 8'ha5);
    chk(rb(6'd3, bd_engine_pkg::OFS_STATUS), 8'h26);
    $display("in done");
  endtask

  task automatic t_toggle();
    bd(6'd2, 8'h88, 8'h40, 8'h00, 8'h04);
    tk(bd_engine_pkg::PID_OUT, 4'h1, 1'b1, 10'h008, 1'b0);
    chk({ths, tst}, {bd_engine_pkg::HS_ACK, 1'b0});
    chk(xd, 0);
    chk(rb(6'd2, bd_engine_pkg::OFS_STATUS), 8'h88);
    tk(bd_engine_pkg::PID_OUT, 4'h1, 1'b0, 10'h008, 1'b0);
    chk({tst, rb(6'd2, bd_engine_pkg::OFS_STATUS)}, 9'h104);
    bd(6'd2, 8'hc8, 8'h40, 8'h00, 8'h04);
    tk(bd_engine_pkg::PID_OUT, 4'h1, 1'b1, 10'h008, 1'b0);
    chk({tst, rb(6'd2, bd_engine_pkg::OFS_STATUS)}, 9'h144);
    $display("toggle done");
  endtask

  task automatic t_stall();
    bd(6'd0, 8'h84, 8'h08, 8'h00, 8'h04);
    tk(bd_engine_pkg::PID_OUT, 4'h0, 1'b0, 10'h008, 1'b0);
    chk({ths, sd[1:0]}, {bd_engine_pkg::HS_STALL, 2'b01});
    chk(rb(6'd0, bd_engine_pkg::OFS_STATUS), 8'h84);
    rr(bd_engine_pkg::REG_STALL, 32'h1);
    bus(1'b1, bd_engine_pkg::REG_STALL, 32'h0000_0001);
    rr(bd_engine_pkg::REG_STALL, 32'h0);
    tk(bd_engine_pkg::PID_OUT, 4'h0, 1'b0, 10'h008, 1'b0);
    rr(bd_engine_pkg::REG_STALL, 32'h1);
    tk(bd_engine_pkg::PID_SETUP, 4'h0, 1'b0, 10'h008, 1'b0);
    chk(ths, bd_engine_pkg::HS_ACK);
    chk(rb(6'd0, bd_engine_pkg::OFS_STATUS), 8'h34);
    rr(bd_engine_pkg::REG_STALL, 32'h0);
    $display("stall done");
  endtask

  task automatic t_pingpong();
    bus(1'b1, bd_engine_pkg::REG_CONFIG, 32'h0000_0002);
    bd(6'd4, 8'h80, 8'h40, 8'h00, 8'h04);
    bd(6'd5, 8'h80, 8'h40, 8'h40, 8'h04);
    tk(bd_engine_pkg::PID_OUT, 4'h1, 1'b0, 10'h001, 1'b0);
    chk(tba, 16'h0400);
    rr(bd_engine_pkg::REG_STATUS, 32'h01);
    rr(bd_engine_pkg::REG_POINTER, 32'h2);
    tk(bd_engine_pkg::PID_OUT, 4'h1, 1'b0, 10'h001, 1'b0);
    chk(tba, 16'h0440);
    rr(bd_engine_pkg::REG_STATUS, 32'h11);
    rr(bd_engine_pkg::REG_POINTER, 32'h0);
    bd(6'd4, 8'h80, 8'h40, 8'h00, 8'h04);
    tk(bd_engine_pkg::PID_OUT, 4'h1, 1'b0, 10'h001, 1'b0);
    rr(bd_engine_pkg::REG_POINTER, 32'h2);
    bus(1'b1, bd_engine_pkg::REG_CONFIG, 32'h0000_0012);
    rr(bd_engine_pkg::REG_POINTER, 32'h0);
    rr(bd_engine_pkg::REG_CONFIG, 32'h2);
    $display("ping-pong done");
  endtask

  // endpoint 1 in slot per mode; code 11 behaves as no ping-pong
  task automatic t_modes();
    logic [5:0] sl [0:3];
    sl = '{6'd3, 6'd4, 6'd6, 6'd3};
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, bd_engine_pkg::REG_CONFIG, 32'h0000_0010 | m);
      bd(sl[m], 8'h80, 8'h01, {2'b00, sl[m]}, 8'h04);
      tk(bd_engine_pkg::PID_IN, 4'h1, 1'b0, 10'h001, 1'b0);
      chk(tba, {8'h04, 2'b00, sl[m]});
    end
    $display("modes done");
  endtask

  initial begin
    error_cnt = 0;
    tests_run = 0;
    cyc = 0;
    xfer_cnt = 0;
    stall_cnt = 0;
    srst_in = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 4'h0;
    wd = 32'h0000_0000;
    repeat (6) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    t_regs();
    t_out();
    t_in();
    t_toggle();
    t_stall();
    t_pingpong();
    t_modes();
    test_done();
  end
endmodule
